// ===== verilog/ism_consts.vh
// Constants for the single-master two-wire bus interface: register indices,
// field positions, reset values and divider figures.
// Assumes inclusion by ism_top.v only; holds definitions and nothing else.
//
// Functional notes
// - Event flag rises on any event; cleared by error-register read or clearing sequence.
// - Events are byte finished, start sent, acknowledge failure, address acknowledged.
// - Direction flag shows 1 for sent, 0 for received byte; clears with byte-finished.
// - Byte-finished rises after each good byte, with interrupt when enabled.
// - Sent byte finishes after acknowledge pulse; cleared by status read then data write.
// - Received byte finishes after acknowledge pulse; cleared by status read then data read.
// - Clock line is held low while byte-finished stays set, until a stop or repeated start is generated.
// - Master flag rises on start write; clears after stop or when disabled.
// - Start-generated flag rises after start; cleared by status read then address write.
// - Disabling the interface clears every status flag.
// - Acknowledge failure rises on missing acknowledge; cleared by error read or disable.
// - Clock line is released while acknowledge failure is set, until a start or stop is requested.
// - Speed select and divider survive disable; only reset or a write change them.
// - Bus clock is CPU clock over 2(N+2) standard or 3(N+2) fast.
// - In transmit mode a data write starts the next byte.
// - First received byte starts after status read then control write; later ones after each data read.
// - Reserved status bits always read zero.
// - All registers reset to zero.
// - Start bit makes a start when bus free, or repeated start as master.
// - Stop bit makes a stop after the current byte or start.
// - Acknowledge enable decides whether received bytes are acknowledged.
`ifndef ISM_CONSTS_VH
`define ISM_CONSTS_VH

// Register indices; byte address is four times the index
`define ISM_IDX_CR 8'h40
`define ISM_IDX_SR1 8'h41
`define ISM_IDX_SR2 8'h42
`define ISM_IDX_CCR 8'h43
`define ISM_IDX_DR 8'h46

`define ISM_RST_VAL 8'h00

// Control register fields
`define ISM_CR_PE 5
`define ISM_CR_START 3
`define ISM_CR_ACK 2
`define ISM_CR_STOP 1
`define ISM_CR_ITE 0

// Main status fields
`define ISM_SR1_EVF 7
`define ISM_SR1_TRA 5
`define ISM_SR1_BTF 3
`define ISM_SR1_MIDL 1
`define ISM_SR1_SB 0

// Error status field
`define ISM_SR2_AF 4

// Clock control fields
`define ISM_CCR_FM 7
`define ISM_DIV_W 7

// Divider figures: period is MUL x (N + OFS) CPU cycles
`define ISM_DIV_OFS 9'h002
`define ISM_STD_MUL 2
`define ISM_FAST_MUL 3

`endif

// ===== verilog/ism_top.v
// Single-master two-wire bus interface: registers, status flags, bus clock
// divider and the byte engine that drives the open-drain clock and data pins.
// Assumes an Avalon-MM master with 32-bit data and pins that are pulled up.
//
// Decided for this implementation: register access over Avalon-MM.
`include "ism_consts.vh"

module ism_top #(
    parameter DIV_W = `ISM_DIV_W
) (
    input wire clock_i,
    input wire nrst_i,
    input wire ce_i,
    input wire [9:0] address_i,
    input wire read_i,
    input wire write_i,
    input wire [31:0] writedata_i,
    input wire [3:0] byteenable_i,
    output reg [31:0] readdata_o,
    output wire waitrequest_o,
    output wire irq_o,
    input wire scl_i,
    output wire scl_o,
    output wire scl_oe_o,
    input wire sda_i,
    output wire sda_o,
    output wire sda_oe_o
);

    localparam [3:0] S_IDLE = 4'h0;
    localparam [3:0] S_RS = 4'h1;
    localparam [3:0] S_STA = 4'h2;
    localparam [3:0] S_STB = 4'h3;
    localparam [3:0] S_LOW = 4'h4;
    localparam [3:0] S_HIGH = 4'h5;
    localparam [3:0] S_HOLD = 4'h6;
    localparam [3:0] S_ERR = 4'h7;
    localparam [3:0] S_SPA = 4'h8;
    localparam [3:0] S_SPB = 4'h9;
    localparam [3:0] S_SPC = 4'ha;

    // Cycles minus one for one step; fast low phase is twice as long
    function [8:0] step_cnt;
        input fm;
        input low;
        input [DIV_W-1:0] n;
        reg [8:0] base;
        begin
            base = {{(9-DIV_W){1'b0}}, n} + `ISM_DIV_OFS;
            if (fm && low) begin
                step_cnt = {base[7:0], 1'b0} - 9'h001;
            end else begin
                step_cnt = base - 9'h001;
            end
        end
    endfunction

    reg rst_m_r, rst_n_r;
    reg scl_m_r, scl_s_r, sda_m_r, sda_s_r;
    reg ack_r;
    reg pe_r, start_r, acken_r, stop_r, ite_r, fm_r;
    reg [DIV_W-1:0] div_r;
    reg [7:0] dr_r;
    reg tra_r, btf_r, master_r, sb_r, af_r, addr_ev_r;
    reg sr1_rd_r, rx_mode_r, go_r, tx_r, addr_r, hold_sda_r, sda_oe_r;
    reg [3:0] st_r;
    reg [8:0] cnt_r;
    reg [3:0] bit_r;
    reg [7:0] shift_r;
    reg [7:0] rd_val;

    wire [7:0] idx = address_i[9:2];
    wire rd_acc = read_i & ack_r;
    wire wr_acc = write_i & ack_r & byteenable_i[0];
    wire [7:0] wd = writedata_i[7:0];
    wire cnt_zero = (cnt_r == 9'h000);
    wire in_hold = (st_r == S_HOLD);
    wire event_flag = sb_r | btf_r | af_r | addr_ev_r;
    wire [8:0] lo_len = step_cnt(fm_r, 1'b1, div_r);
    wire [8:0] hi_len = step_cnt(fm_r, 1'b0, div_r);
    wire tx_bit_low = (bit_r != 4'h8) & ~shift_r[7];
    wire rx_ack_low = (bit_r == 4'h8) & acken_r;
    wire bit_low = tx_r ? tx_bit_low : rx_ack_low;
    wire hi_wait = (st_r == S_HIGH) & ~scl_s_r & (cnt_r + 9'h002 <= hi_len);
    wire sda_low = (st_r == S_STB) | (st_r == S_SPA) | (st_r == S_SPB) |
                   (in_hold & hold_sda_r) |
                   (((st_r == S_LOW) | (st_r == S_HIGH)) & bit_low);

    // Reset release through two flip-flops
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_m_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_m_r <= 1'b1;
            rst_n_r <= rst_m_r;
        end
    end

    // Bus pin synchronisers
    always @(posedge clock_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            scl_m_r <= 1'b1;
            scl_s_r <= 1'b1;
            sda_m_r <= 1'b1;
            sda_s_r <= 1'b1;
        end else if (ce_i) begin
            scl_m_r <= scl_i;
            scl_s_r <= scl_m_r;
            sda_m_r <= sda_i;
            sda_s_r <= sda_m_r;
        end
    end

    // Register read mux
    always @* begin
        case (idx)
            `ISM_IDX_CR: begin
                rd_val = {2'b00, pe_r, 1'b0, start_r, acken_r, stop_r, ite_r};
            end
            `ISM_IDX_SR1: begin
                rd_val = {event_flag, 1'b0, tra_r, 1'b0, btf_r, 1'b0, master_r, sb_r};
            end
            `ISM_IDX_SR2: begin
                rd_val = {3'b000, af_r, 4'h0};
            end
            `ISM_IDX_CCR: begin
                rd_val = {fm_r, div_r};
            end
            `ISM_IDX_DR: begin
                rd_val = dr_r;
            end
            default: begin
                rd_val = 8'h00;
            end
        endcase
    end

    // One wait state per access; read data captured in the waiting cycle
    assign waitrequest_o = (read_i | write_i) & ~ack_r;

    always @(posedge clock_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            ack_r <= 1'b0;
            readdata_o <= 32'h0000_0000;
        end else if (ce_i) begin
            ack_r <= (read_i | write_i) & ~ack_r;
            if (read_i && !ack_r) begin
                readdata_o <= {24'h00_0000, rd_val};
            end
        end
    end

    // Registers, flags and byte engine
    always @(posedge clock_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            pe_r <= 1'b0;
            start_r <= 1'b0;
            acken_r <= 1'b0;
            stop_r <= 1'b0;
            ite_r <= 1'b0;
            fm_r <= 1'b0;
            div_r <= {DIV_W{1'b0}};
            dr_r <= `ISM_RST_VAL;
            tra_r <= 1'b0;
            btf_r <= 1'b0;
            master_r <= 1'b0;
            sb_r <= 1'b0;
            af_r <= 1'b0;
            addr_ev_r <= 1'b0;
            sr1_rd_r <= 1'b0;
            rx_mode_r <= 1'b0;
            go_r <= 1'b0;
            tx_r <= 1'b0;
            addr_r <= 1'b0;
            hold_sda_r <= 1'b0;
            st_r <= S_IDLE;
            sda_oe_r <= 1'b0;
            cnt_r <= 9'h000;
            bit_r <= 4'h0;
            shift_r <= 8'h00;
        end else if (ce_i) begin
            // Software accesses
            if (wr_acc && idx == `ISM_IDX_CR) begin
                sr1_rd_r <= 1'b0;
                if (!pe_r) begin
                    pe_r <= wd[`ISM_CR_PE];
                end else begin
                    pe_r <= wd[`ISM_CR_PE];
                    start_r <= wd[`ISM_CR_START];
                    acken_r <= wd[`ISM_CR_ACK];
                    stop_r <= wd[`ISM_CR_STOP];
                    ite_r <= wd[`ISM_CR_ITE];
                    if (wd[`ISM_CR_START]) begin
                        master_r <= 1'b1;
                    end
                    if (sr1_rd_r && addr_ev_r) begin
                        addr_ev_r <= 1'b0;
                        if (rx_mode_r) begin
                            go_r <= 1'b1;
                            tx_r <= 1'b0;
                            addr_r <= 1'b0;
                        end
                    end
                end
            end
            if (wr_acc && idx == `ISM_IDX_CCR) begin
                fm_r <= wd[`ISM_CCR_FM];
                div_r <= wd[DIV_W-1:0];
            end
            if (wr_acc && idx == `ISM_IDX_DR) begin
                dr_r <= wd;
                sr1_rd_r <= 1'b0;
                if (in_hold && sb_r && sr1_rd_r) begin
                    sb_r <= 1'b0;
                    shift_r <= wd;
                    rx_mode_r <= wd[0];
                    tx_r <= 1'b1;
                    addr_r <= 1'b1;
                    go_r <= 1'b1;
                end else if (in_hold && !sb_r && !addr_ev_r && !rx_mode_r &&
                             (!btf_r || sr1_rd_r)) begin
                    btf_r <= 1'b0;
                    tra_r <= 1'b0;
                    shift_r <= wd;
                    tx_r <= 1'b1;
                    addr_r <= 1'b0;
                    go_r <= 1'b1;
                end
            end
            if (rd_acc && idx == `ISM_IDX_DR) begin
                sr1_rd_r <= 1'b0;
                if (sr1_rd_r && btf_r && rx_mode_r) begin
                    btf_r <= 1'b0;
                    tra_r <= 1'b0;
                    tx_r <= 1'b0;
                    addr_r <= 1'b0;
                    go_r <= 1'b1;
                end
            end
            if (rd_acc && idx == `ISM_IDX_SR1) begin
                sr1_rd_r <= 1'b1;
            end
            if (rd_acc && idx == `ISM_IDX_SR2) begin
                af_r <= 1'b0;
            end

            // Step counter; high phase covers the sync delay, then waits on a stretch
            if (!cnt_zero && !hi_wait) begin
                cnt_r <= cnt_r - 9'h001;
            end
            sda_oe_r <= sda_low; // Data moves a cycle after the clock falls

            // Byte engine
            case (st_r)
                S_IDLE: begin
                    if (start_r && pe_r) begin
                        st_r <= S_STA;
                        cnt_r <= hi_len;
                    end
                end
                S_RS: begin
                    if (cnt_zero) begin
                        st_r <= S_STA;
                        cnt_r <= hi_len;
                    end
                end
                S_STA: begin
                    if (!scl_s_r || !sda_s_r) begin
                        cnt_r <= hi_len;
                    end else if (cnt_zero) begin
                        st_r <= S_STB;
                        cnt_r <= hi_len;
                    end
                end
                S_STB: begin
                    if (cnt_zero) begin
                        st_r <= S_HOLD;
                        go_r <= 1'b0; // No stale byte request after a start
                        hold_sda_r <= 1'b1;
                        start_r <= 1'b0;
                        sb_r <= 1'b1;
                    end
                end
                S_HOLD: begin
                    if (start_r) begin
                        st_r <= S_RS;
                        cnt_r <= lo_len;
                        go_r <= 1'b0;
                    end else if (stop_r) begin
                        st_r <= S_SPA;
                        cnt_r <= lo_len;
                        go_r <= 1'b0;
                    end else if (go_r) begin
                        st_r <= S_LOW;
                        cnt_r <= lo_len;
                        bit_r <= 4'h0;
                        hold_sda_r <= 1'b0;
                        go_r <= 1'b0;
                    end
                end
                S_LOW: begin
                    if (cnt_zero) begin
                        st_r <= S_HIGH;
                        cnt_r <= hi_len;
                    end
                end
                S_HIGH: begin
                    if (cnt_zero && scl_s_r) begin
                        if (bit_r != 4'h8) begin
                            shift_r <= {shift_r[6:0], sda_s_r};
                            bit_r <= bit_r + 4'h1;
                            st_r <= S_LOW;
                            cnt_r <= lo_len;
                        end else if (tx_r && sda_s_r) begin
                            af_r <= 1'b1;
                            st_r <= S_ERR;
                        end else if (addr_r) begin
                            addr_ev_r <= 1'b1;
                            st_r <= S_HOLD;
                        end else begin
                            btf_r <= 1'b1;
                            tra_r <= tx_r;
                            if (!tx_r) begin
                                dr_r <= shift_r;
                            end
                            st_r <= S_HOLD;
                        end
                    end
                end
                S_ERR: begin
                    if (start_r) begin
                        st_r <= S_STA;
                        cnt_r <= hi_len;
                    end else if (stop_r) begin
                        st_r <= S_SPA;
                        cnt_r <= lo_len;
                    end
                end
                S_SPA: begin
                    if (cnt_zero) begin
                        st_r <= S_SPB;
                        cnt_r <= hi_len;
                    end
                end
                S_SPB: begin
                    if (!scl_s_r) begin
                        cnt_r <= hi_len;
                    end else if (cnt_zero) begin
                        st_r <= S_SPC;
                        cnt_r <= hi_len;
                    end
                end
                S_SPC: begin
                    if (cnt_zero) begin
                        st_r <= S_IDLE;
                        stop_r <= 1'b0;
                        master_r <= 1'b0;
                    end
                end
                default: begin
                    st_r <= S_IDLE;
                end
            endcase

            // Disabled interface: flags, control bits and engine forced idle
            if (!pe_r) begin
                start_r <= 1'b0;
                acken_r <= 1'b0;
                stop_r <= 1'b0;
                ite_r <= 1'b0;
                tra_r <= 1'b0;
                btf_r <= 1'b0;
                sb_r <= 1'b0;
                af_r <= 1'b0;
                addr_ev_r <= 1'b0;
                master_r <= 1'b0;
                sr1_rd_r <= 1'b0;
                go_r <= 1'b0;
                hold_sda_r <= 1'b0;
                st_r <= S_IDLE;
            end
        end
    end

    // Open-drain pins: enable pulls the line low
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;
    assign scl_oe_o = pe_r & ((st_r == S_RS) | (st_r == S_LOW) | (st_r == S_SPA) |
                      in_hold);
    assign sda_oe_o = pe_r & sda_oe_r;

    // Merged interrupt request
    assign irq_o = ite_r & (btf_r | sb_r | af_r);

endmodule

// ===== bench/ism_chk.sv
// Checker for the two-wire bus interface, bound to ism_top.
// Assumes one clock and no request before the internal reset has ended.
module ism_chk #(
    parameter DIV_W = 7
) (
    input wire clock_i,
    input wire nrst_i,
    input wire ce_i,
    input wire [9:0] address_i,
    input wire read_i,
    input wire write_i,
    input wire [31:0] writedata_i,
    input wire [3:0] byteenable_i,
    input wire [31:0] readdata_o,
    input wire waitrequest_o,
    input wire irq_o,
    input wire scl_i,
    input wire scl_o,
    input wire scl_oe_o,
    input wire sda_i,
    input wire sda_o,
    input wire sda_oe_o
);
    // Taken accesses per register
    wire rd_tk = read_i && !waitrequest_o;
    wire wr_cr = write_i && !waitrequest_o && byteenable_i[0] && address_i[9:2] == 8'h40;
    wire rd_s1 = rd_tk && address_i[9:2] == 8'h41;
    wire rd_s2 = rd_tk && address_i[9:2] == 8'h42;
    reg pe_r;
    reg ite_r;
    // Shadow of enable and interrupt enable; first write only enables
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pe_r <= 1'b0;
            ite_r <= 1'b0;
        end else if (ce_i && wr_cr) begin
            pe_r <= writedata_i[5];
            ite_r <= pe_r & writedata_i[5] & writedata_i[0];
        end
    end
    default clocking @(posedge clock_i); endclocking
    default disable iff (!nrst_i);
    chk_wait_once: assert property ($rose(read_i || write_i) |-> waitrequest_o ##1 !waitrequest_o)
        else $error("wait state not exactly one cycle");
    chk_sr1_rsvd: assert property (rd_s1 |-> (readdata_o & 32'hffffff54) == 32'h0)
        else $error("status one reserved bit set");
    chk_sr2_rsvd: assert property (rd_s2 |-> (readdata_o & 32'hffffffef) == 32'h0)
        else $error("status two reserved bit set");
    chk_event_or: assert property (rd_s1 && (readdata_o[3] || readdata_o[0]) |-> readdata_o[7])
        else $error("event flag missing");
    chk_dir_btf: assert property (rd_s1 && readdata_o[5] |-> readdata_o[3])
        else $error("direction without byte finished");
    chk_sb_hold: assert property (rd_s1 && readdata_o[0] |-> scl_oe_o && readdata_o[1])
        else $error("clock not held after start");
    chk_af_free: assert property (rd_s2 && readdata_o[4] |-> !scl_oe_o)
        else $error("clock held during ack failure");
    chk_irq_gate: assert property (!ite_r |-> !irq_o)
        else $error("interrupt without enable");
    chk_irq_merge: assert property (rd_s1 && ite_r && (readdata_o[3] || readdata_o[0]) |-> irq_o)
        else $error("interrupt missing");
    chk_pe_off: assert property (wr_cr && !writedata_i[5] |=> !irq_o && !scl_oe_o && !sda_oe_o)
        else $error("outputs not released on disable");
    chk_off_zero: assert property (rd_s1 && !pe_r |-> readdata_o == 32'h0)
        else $error("status set while disabled");
endmodule

bind ism_top ism_chk #(.DIV_W(DIV_W)) u_ism_chk (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .address_i(address_i),
    .read_i(read_i),
    .write_i(write_i),
    .writedata_i(writedata_i),
    .byteenable_i(byteenable_i),
    .readdata_o(readdata_o),
    .waitrequest_o(waitrequest_o),
    .irq_o(irq_o),
    .scl_i(scl_i),
    .scl_o(scl_o),
    .scl_oe_o(scl_oe_o),
    .sda_i(sda_i),
    .sda_o(sda_o),
    .sda_oe_o(sda_oe_o)
);

// ===== bench/ism_slave.sv
// Behavioural slave on the two-wire bus: acknowledges any address, keeps
// written bytes, returns a fixed byte on reads. Pull-ups sit outside.
module ism_slave (
    input wire scl_i,
    input wire sda_i,
    input wire nack_i,
    input wire slow_i,
    input wire [7:0] rd_byte_i,
    output logic sda_pull_o,
    output logic scl_pull_o,
    output logic [7:0] last_byte_o
);
    timeunit 1ns;
    timeprecision 1ps;
    integer cnt = 0;
    logic [7:0] sh = 8'h00;
    logic act = 1'b0;
    logic rw = 1'b0;
    logic adr = 1'b0;
    initial begin
        sda_pull_o = 1'b0;
        scl_pull_o = 1'b0;
        last_byte_o = 8'h00;
    end
    // Start and stop while the clock line is high
    always @(negedge sda_i) begin
        if (scl_i) begin
            cnt = 0;
            act = 1'b1;
            adr = 1'b1;
        end
    end
    always @(posedge sda_i) begin
        if (scl_i) begin
            act = 1'b0;
            sda_pull_o = 1'b0;
        end
    end
    // Shift in on the rising clock, MSB first, ninth bit is the ack
    always @(posedge scl_i) begin
        if (act) begin
            if (cnt < 8) sh = {sh[6:0], sda_i};
            cnt = cnt + 1;
        end
    end
    // Drive ack or read data while the clock is low; optional stretch
    always @(negedge scl_i) begin
        if (act) begin
            sda_pull_o = 1'b0;
            if (cnt == 8) begin
                if (adr) rw = sh[0];
                else if (!rw) last_byte_o = sh;
                sda_pull_o = (adr || !rw) && !nack_i;
            end else if (cnt == 9) begin
                cnt = 0;
                adr = 1'b0;
            end
            if (rw && !adr && cnt < 8) sda_pull_o = ~rd_byte_i[7 - cnt];
            if (slow_i) begin
                scl_pull_o = 1'b1;
                #400 scl_pull_o = 1'b0;
            end
        end
    end
endmodule

// ===== bench/ism_tb_top.sv
// Testbench for the two-wire bus interface: register tasks and bus scenarios.
// Assumes ism_top with its bound checker and the slave model ism_slave.
module ism_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int N = 3;
    logic clock_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [9:0] address_i = 10'h000;
    logic read_i = 1'b0;
    logic write_i = 1'b0;
    logic [31:0] writedata_i = 32'h0;
    logic [3:0] byteenable_i = 4'hf;
    logic [3:0] be = 4'hf;
    logic nack = 1'b0;
    logic slow = 1'b0;
    logic [7:0] r;
    wire [31:0] readdata_o;
    wire waitrequest_o, irq_o, scl_o, scl_oe_o, sda_o, sda_oe_o, s_sda, s_scl;
    wire [7:0] s_byte;
    wire scl_w = ~(scl_oe_o | s_scl);
    wire sda_w = ~(sda_oe_o | s_sda);
    integer miscompares = 0;
    integer num_checks = 0;
    integer cyc = 0;
    integer lst = 0;
    integer per = 0;
    logic [7:0] ix [6] = '{8'h40, 8'h41, 8'h42, 8'h43, 8'h46, 8'h45};
    ism_top u_ism_top (
        .clock_i(clock_i),
        .nrst_i(nrst_i),
        .ce_i(1'b1),
        .address_i(address_i),
        .read_i(read_i),
        .write_i(write_i),
        .writedata_i(writedata_i),
        .byteenable_i(byteenable_i),
        .readdata_o(readdata_o),
        .waitrequest_o(waitrequest_o),
        .irq_o(irq_o),
        .scl_i(scl_w),
        .scl_o(scl_o),
        .scl_oe_o(scl_oe_o),
        .sda_i(sda_w),
        .sda_o(sda_o),
        .sda_oe_o(sda_oe_o)
    );
    ism_slave u_ism_slave (
        .scl_i(scl_w),
        .sda_i(sda_w),
        .nack_i(nack),
        .slow_i(slow),
        .rd_byte_i(8'hc3),
        .sda_pull_o(s_sda),
        .scl_pull_o(s_scl),
        .last_byte_o(s_byte)
    );
    // Clock and bus clock period monitor
    always #12.5 clock_i = ~clock_i;
    always @(posedge clock_i) cyc <= cyc + 1;
    always @(posedge scl_w) begin
        per = cyc - lst;
        lst = cyc;
    end
    task end_of_test;
        begin
            $display("checks %0d mismatches %0d", num_checks, miscompares);
            if (miscompares == 0 && num_checks > 0) $display("bench passed");
            else $display("bench failed");
            $finish;
        end
    endtask
    task cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
        begin
            num_checks++;
            if (g !== e) begin
                $display("BAD %s expected %h seen %h", nm, e, g);
                miscompares++;
            end
        end
    endtask
    // One Avalon access; held until waitrequest is seen low
    task acc(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        integer k;
        begin
            address_i <= {idx, 2'b00};
            writedata_i <= {24'h0, wd};
            byteenable_i <= be;
            write_i <= wr;
            read_i <= ~wr;
            k = 0;
            @(negedge clock_i);
            while (waitrequest_o !== 1'b0) begin
                k++;
                if (k > 20) begin
                    cmp("waitrequest", 8'h00, 8'h01);
                    end_of_test;
                end
                @(negedge clock_i);
            end
            @(posedge clock_i);
            r = readdata_o[7:0];
            write_i <= 1'b0;
            read_i <= 1'b0;
            @(posedge clock_i);
        end
    endtask
    task wr(input logic [7:0] idx, input logic [7:0] wd);
        acc(1'b1, idx, wd);
    endtask
    task chk(input string nm, input logic [7:0] idx, input logic [7:0] e);
        begin
            acc(1'b0, idx, 8'h00);
            cmp(nm, e, r);
        end
    endtask
    // Read the main status until bit b equals v, bounded
    task poll(input int b, input logic v);
        integer k;
        begin
            k = 0;
            acc(1'b0, 8'h41, 8'h00);
            while (r[b] !== v) begin
                k++;
                if (k > 400) begin
                    cmp("poll", 8'h00, 8'h01);
                    end_of_test;
                end
                acc(1'b0, 8'h41, 8'h00);
            end
        end
    endtask
    task done(input string nm);
        $display("test %s done", nm);
    endtask
    // Main sequence
    initial begin
        repeat (10) @(posedge clock_i);
        nrst_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        foreach (ix[i]) chk("reset", ix[i], 8'h00);
        wr(8'h40, 8'h2d);
        chk("cr first", 8'h40, 8'h20);
        wr(8'h41, 8'hff);
        chk("sr1 write", 8'h41, 8'h00);
        be = 4'he;
        wr(8'h43, 8'h07);
        be = 4'hf;
        chk("ccr masked", 8'h43, 8'h00);
        wr(8'h43, 8'h80 | N);
        wr(8'h40, 8'h00);
        chk("ccr kept", 8'h43, 8'h80 | N);
        wr(8'h43, N);
        done("registers");
        wr(8'h40, 8'h20);
        wr(8'h40, 8'h29);
        poll(0, 1'b1);
        cmp("sr1 start", 8'h83, r);
        cmp("irq on", 8'h01, {7'h0, irq_o});
        wr(8'h40, 8'h00);
        chk("sr1 off", 8'h41, 8'h00);
        cmp("irq off", 8'h00, {7'h0, irq_o});
        done("disable");
        wr(8'h40, 8'h20);
        wr(8'h40, 8'h2d);
        poll(0, 1'b1);
        wr(8'h46, 8'ha0);
        poll(7, 1'b1);
        cmp("sr1 addr", 8'h82, r);
        wr(8'h40, 8'h25);
        wr(8'h46, 8'h5a);
        poll(3, 1'b1);
        cmp("sr1 tx", 8'haa, r);
        cmp("scl held", 8'h00, {7'h0, scl_w});
        cmp("pin drive", 8'h00, {6'h0, scl_o, sda_o});
        cmp("std period", 2 * (N + 2), per[7:0]);
        cmp("slave byte", 8'h5a, s_byte);
        nack <= 1'b1;
        wr(8'h46, 8'h33);
        poll(7, 1'b1);
        cmp("sr1 af", 8'h82, r);
        chk("sr2 af", 8'h42, 8'h10);
        cmp("scl free", 8'h01, {7'h0, scl_w});
        chk("sr2 clear", 8'h42, 8'h00);
        chk("sr1 clear", 8'h41, 8'h02);
        nack <= 1'b0;
        wr(8'h40, 8'h27);
        poll(1, 1'b0);
        cmp("sr1 stop", 8'h00, r);
        chk("cr stop", 8'h40, 8'h25);
        done("transmit");
        wr(8'h43, 8'h80 | N);
        wr(8'h40, 8'h2d);
        poll(0, 1'b1);
        wr(8'h46, 8'ha1);
        poll(7, 1'b1);
        wr(8'h40, 8'h25);
        poll(3, 1'b1);
        cmp("sr1 rx", 8'h8a, r);
        cmp("fast period", 3 * (N + 2), per[7:0]);
        slow <= 1'b1;
        chk("rx byte1", 8'h46, 8'hc3);
        poll(3, 1'b1);
        wr(8'h40, 8'h27);
        poll(3, 1'b1);
        chk("rx byte2", 8'h46, 8'hc3);
        poll(1, 1'b0);
        cmp("sr1 end", 8'h00, r);
        done("receive");
        end_of_test;
    end
endmodule
